// >>> rtl/pmsr_clock_out.sv
// Divided clock output that parks high while disabled
`timescale 1ns/1ps
module pmsr_clock_out
    import pmsr_pkg::*;
#(
    parameter int HALF_CYCLES = 1
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clock_out_disable,
    output logic clock_output_pin
);

    if (HALF_CYCLES < 1 || HALF_CYCLES > 256)
    begin : bad_half
        $error("pmsr_clock_out: HALF_CYCLES must be 1..256");
    end

    localparam logic [7:0] LAST = 8'(HALF_CYCLES - 1);

    pmsr_clk_state_type state;
    pmsr_clk_state_type next_state;

    always_comb
    begin
        next_state = state;
        if (sys_rst || clock_out_disable)
        begin
            // Parked high so a restart begins with a full high phase
            next_state.count = 8'h00;
            next_state.level = 1'b1;
        end
        else if (state.count == LAST)
        begin
            next_state.count = 8'h00;
            next_state.level = !state.level;
        end
        else
        begin
            next_state.count = state.count + 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        state <= next_state;
    end

    assign clock_output_pin = state.level;

endmodule

// >>> rtl/pmsr_defs.svh
// Offsets, field positions, reset values and address bounds of the mode block
`ifndef PMSR_DEFS_SVH
`define PMSR_DEFS_SVH

`define PMSR_OFFSET 8'h1d
`define PMSR_PTR_MSB 15
`define PMSR_PTR_LSB 7
`define PMSR_ROM_SEL_BIT 6
`define PMSR_OVERLAY_BIT 5
`define PMSR_VISIBLE_BIT 4
`define PMSR_DATA_ROM_BIT 3
`define PMSR_CLK_DISABLE_BIT 2
`define PMSR_MUL_SAT_BIT 1
`define PMSR_STORE_SAT_BIT 0
`define PMSR_RESET_PTR 9'h1ff
`define PMSR_CLK_OUT_HALF 1
`define PMSR_RESET_LOW 6'h00
`define PMSR_RESET_VECTOR 16'hff80
`define PMSR_PAGE0_HI 16'h007f
`define PMSR_RAM_LO 16'h0080
`define PMSR_RAM_HI 16'h9fff

`endif

// >>> rtl/pmsr_pkg.sv
// Types shared by the processor mode status block
package pmsr_pkg;

    typedef struct packed {
        logic [8:0] vector_page_pointer;
        logic rom_select_mode;
        logic ram_overlay;
        logic address_visibility;
        logic data_rom_map;
        logic clock_out_disable;
        logic multiply_saturate;
        logic store_saturate;
    } pmsr_mode_type;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } pmsr_access_type;

    typedef struct packed {
        logic rom;
        logic ram;
        logic external;
    } pmsr_select_type;

    typedef struct packed {
        pmsr_mode_type mode;
        logic [15:0] read_data;
        logic [15:0] ext_addr;
        logic [15:0] vector_addr;
        pmsr_select_type prog_sel;
        pmsr_select_type data_sel;
    } pmsr_top_state_type;

    typedef struct packed {
        logic [7:0] count;
        logic level;
    } pmsr_clk_state_type;

endpackage

// >>> rtl/pmsr_saturate.sv
// Registered signed saturation from a wide value to a narrower one
`timescale 1ns/1ps
module pmsr_saturate
    import pmsr_pkg::*;
#(
    parameter int IN_W = 40,
    parameter int OUT_W = 16
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic [IN_W-1:0] value_in,
    output logic [OUT_W-1:0] value_out
);

    if (OUT_W < 2 || OUT_W >= IN_W)
    begin : bad_width
        $error("pmsr_saturate: OUT_W must be 2..IN_W-1");
    end

    typedef struct packed {
        logic [OUT_W-1:0] result;
    } pmsr_sat_state_type;

    pmsr_sat_state_type state;
    pmsr_sat_state_type next_state;
    logic overflow;

    // Upper bits must all copy the result's sign, else the value overflows
    assign overflow = !((&value_in[IN_W-1:OUT_W-1])
        || !(|value_in[IN_W-1:OUT_W-1]));

    always_comb
    begin
        next_state = state;
        if (sys_rst)
        begin
            next_state.result = '0;
        end
        else if (enable && overflow)
        begin
            next_state.result = value_in[IN_W-1]
                ? {1'b1, {(OUT_W-1){1'b0}}}
                : {1'b0, {(OUT_W-1){1'b1}}};
        end
        else
        begin
            next_state.result = value_in[OUT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        state <= next_state;
    end

    assign value_out = state.result;

endmodule

// >>> rtl/pmsr_top.sv
// Processor mode status register with memory map, trace and saturation
// **********************************************************************
// **********************************************************************
`timescale 1ns/1ps
`include "pmsr_defs.svh"
module pmsr_top
    import pmsr_pkg::*;
#(
    parameter logic [15:0] PROG_ROM_LO = 16'hc000,
    parameter logic [15:0] PROG_ROM_HI = 16'hffff,
    parameter logic [15:0] DATA_ROM_LO = 16'hf000,
    parameter logic [15:0] DATA_ROM_HI = 16'hfeff,
    parameter int CLK_OUT_HALF_CYCLES = `PMSR_CLK_OUT_HALF
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic rom_select_mode_pin,
    input wire logic soft_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire pmsr_access_type prog_access,
    input wire pmsr_access_type data_access,
    output pmsr_select_type prog_select,
    output pmsr_select_type data_select,
    output logic [15:0] ext_addr,
    input wire logic [4:0] vector_index,
    output logic [15:0] vector_addr,
    output logic clock_output_pin,
    input wire logic overflow_mode,
    input wire logic fractional_mode,
    input wire logic signed [15:0] mul_a,
    input wire logic signed [15:0] mul_b,
    output logic [31:0] mul_product,
    input wire logic [39:0] store_value,
    output logic [15:0] store_data
);

    if (PROG_ROM_LO > PROG_ROM_HI || DATA_ROM_LO > DATA_ROM_HI)
    begin : bad_range
        $error("pmsr_top: ROM range bounds are reversed");
    end

    pmsr_top_state_type state;
    pmsr_top_state_type next_state;
    logic reg_hit;
    logic prog_in_ram;
    logic prog_in_rom;
    logic data_in_ram;
    logic data_in_rom;
    logic signed [31:0] product_raw;
    logic [32:0] product_scaled;
    logic mul_sat_enable;

    // **********************************************************************
    // Address decode
    // **********************************************************************
    assign reg_hit = reg_addr == `PMSR_OFFSET;

    assign prog_in_ram = prog_access.addr >= `PMSR_RAM_LO
        && prog_access.addr <= `PMSR_RAM_HI
        && prog_access.addr > `PMSR_PAGE0_HI;
    assign prog_in_rom = prog_access.addr >= PROG_ROM_LO
        && prog_access.addr <= PROG_ROM_HI;
    assign data_in_ram = data_access.addr >= `PMSR_RAM_LO
        && data_access.addr <= `PMSR_RAM_HI;
    assign data_in_rom = data_access.addr >= DATA_ROM_LO
        && data_access.addr <= DATA_ROM_HI;

    // **********************************************************************
    // State update
    // **********************************************************************
    always_comb
    begin
        next_state = state;
        next_state.read_data = 16'h0000;
        if (sys_rst)
        begin
            next_state.mode.vector_page_pointer = `PMSR_RESET_PTR;
            // Pin is looked at only while reset holds
            next_state.mode.rom_select_mode = rom_select_mode_pin;
            {next_state.mode.ram_overlay,
             next_state.mode.address_visibility,
             next_state.mode.data_rom_map,
             next_state.mode.clock_out_disable,
             next_state.mode.multiply_saturate,
             next_state.mode.store_saturate} = `PMSR_RESET_LOW;
            next_state.ext_addr = 16'h0000;
            next_state.vector_addr = `PMSR_RESET_VECTOR;
            next_state.prog_sel = '0;
            next_state.data_sel = '0;
        end
        else
        begin
            if (soft_reset)
            begin
                // Pointer and ROM select survive
                {next_state.mode.ram_overlay,
                 next_state.mode.address_visibility,
                 next_state.mode.data_rom_map,
                 next_state.mode.clock_out_disable,
                 next_state.mode.multiply_saturate,
                 next_state.mode.store_saturate} = `PMSR_RESET_LOW;
            end
            if (reg_write && reg_hit)
            begin
                next_state.mode = pmsr_mode_type'(reg_wdata);
            end
            if (reg_read && reg_hit)
            begin
                next_state.read_data = state.mode;
            end

            next_state.vector_addr =
                {state.mode.vector_page_pointer, vector_index, 2'b00};

            next_state.prog_sel.rom = prog_access.valid && prog_in_rom
                && !state.mode.rom_select_mode;
            next_state.prog_sel.ram = prog_access.valid && prog_in_ram
                && state.mode.ram_overlay && !next_state.prog_sel.rom;
            next_state.prog_sel.external = prog_access.valid
                && !next_state.prog_sel.rom && !next_state.prog_sel.ram;

            next_state.data_sel.ram = data_access.valid && data_in_ram;
            next_state.data_sel.rom = data_access.valid && data_in_rom
                && state.mode.data_rom_map && !data_in_ram;
            // Page 0 holds on-chip registers, never an outside access
            next_state.data_sel.external = data_access.valid
                && !data_in_ram && !next_state.data_sel.rom
                && data_access.addr > `PMSR_PAGE0_HI;

            // Program side wins the pins when both go out at once
            if (prog_access.valid && state.mode.address_visibility)
            begin
                next_state.ext_addr = prog_access.addr;
            end
            else if (next_state.prog_sel.external)
            begin
                next_state.ext_addr = prog_access.addr;
            end
            else if (next_state.data_sel.external)
            begin
                next_state.ext_addr = data_access.addr;
            end
            // Otherwise the pins keep the last address driven onto them, traced or external
        end
    end

    always_ff @(posedge clk_sys)
    begin
        state <= next_state;
    end

    assign reg_rdata = state.read_data;
    assign prog_select = state.prog_sel;
    assign data_select = state.data_sel;
    assign ext_addr = state.ext_addr;
    assign vector_addr = state.vector_addr;

    // **********************************************************************
    // Clock output and saturation
    // **********************************************************************
    pmsr_clock_out #(
        .HALF_CYCLES(CLK_OUT_HALF_CYCLES)
    ) u_clock_out (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clock_out_disable(state.mode.clock_out_disable),
        .clock_output_pin(clock_output_pin)
    );

    assign product_raw = mul_a * mul_b;
    // Fractional mode doubles the product, so 8000h squared overflows
    assign product_scaled = fractional_mode ? {product_raw, 1'b0}
        : {product_raw[31], product_raw};
    assign mul_sat_enable = state.mode.multiply_saturate
        && overflow_mode && fractional_mode;

    pmsr_saturate #(
        .IN_W(33),
        .OUT_W(32)
    ) u_mul_sat (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .enable(mul_sat_enable),
        .value_in(product_scaled),
        .value_out(mul_product)
    );

    // Caller shifts first, so saturation sees the shifted value
    pmsr_saturate #(
        .IN_W(40),
        .OUT_W(16)
    ) u_store_sat (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .enable(state.mode.store_saturate),
        .value_in(store_value),
        .value_out(store_data)
    );

    // **********************************************************************
    // Assertions
    // **********************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence reset_release_s;
        $past(sys_rst);
    endsequence

    sequence clk_disabled_s;
        state.mode.clock_out_disable [*2];
    endsequence

    reset_pointer_a: assert property (
        reset_release_s |-> state.mode.vector_page_pointer == 9'h1ff
            && vector_addr == 16'hff80)
        else $error("vector page pointer not all ones after reset");

    reset_saturate_a: assert property (
        reset_release_s |-> !state.mode.multiply_saturate
            && !state.mode.store_saturate)
        else $error("saturate bits not clear after reset");

    pin_sample_a: assert property (
        reset_release_s |->
            state.mode.rom_select_mode == $past(rom_select_mode_pin))
        else $error("rom select bit did not take the mode pin");

    soft_keep_a: assert property (
        soft_reset && !(reg_write && reg_hit) |=>
            $stable(state.mode.vector_page_pointer)
            && $stable(state.mode.rom_select_mode) && !state.mode.ram_overlay)
        else $error("software reset disturbed kept fields");

    write_read_a: assert property (
        reg_write && reg_hit && !soft_reset ##1 reg_read && reg_hit
            && !reg_write |=> reg_rdata == $past(reg_wdata, 2))
        else $error("written mode value not read back");

    vector_page_a: assert property (
        1'b1 |=> vector_addr[15:7] == $past(state.mode.vector_page_pointer)
            && vector_addr[6:2] == $past(vector_index)
            && vector_addr[1:0] == 2'b00)
        else $error("vector address not on selected page");

    rom_decode_a: assert property (
        prog_access.valid && prog_in_rom |=>
            prog_select.rom == !$past(state.mode.rom_select_mode)
            && (prog_select.rom || prog_select.ram || prog_select.external))
        else $error("program rom decode wrong for rom select");

    overlay_map_a: assert property (
        prog_access.valid && prog_access.addr >= 16'h0080
            && prog_access.addr <= 16'h9fff && !prog_in_rom |=>
            prog_select.ram == $past(state.mode.ram_overlay))
        else $error("overlay ram not mapped as the overlay bit says");

    page_zero_a: assert property (
        prog_access.valid && prog_access.addr <= 16'h007f |=>
            !prog_select.ram)
        else $error("data page 0 mapped into program space");

    data_ram_a: assert property (
        data_access.valid && data_access.addr >= 16'h0080
            && data_access.addr <= 16'h9fff |=>
            data_select.ram && !data_select.external)
        else $error("data ram range not decoded");

    vis_hold_a: assert property (
        !state.mode.address_visibility && !next_state.prog_sel.external
            && !next_state.data_sel.external |=> $stable(ext_addr))
        else $error("address pins moved without an external access");

    vis_trace_a: assert property (
        state.mode.address_visibility && prog_access.valid |=>
            ext_addr == $past(prog_access.addr))
        else $error("program address not visible on the pins");

    data_rom_a: assert property (
        data_select.rom |-> $past(state.mode.data_rom_map)
            && $past(data_in_rom))
        else $error("data rom decoded while not enabled");

    clk_park_a: assert property (
        clk_disabled_s |-> clock_output_pin ##1
            (!state.mode.clock_out_disable || clock_output_pin))
        else $error("clock output not parked high");

    mul_sat_a: assert property (
        mul_sat_enable && mul_a == 16'sh8000 && mul_b == 16'sh8000 |=>
            mul_product == 32'h7fffffff)
        else $error("fractional product not saturated");

    store_sat_a: assert property (
        state.mode.store_saturate && !store_value[39]
            && store_value > 40'h0000007fff |=> store_data == 16'h7fff)
        else $error("stored accumulator not saturated");

    soft_write_a: assert property (
        soft_reset && reg_write && reg_hit |=>
            state.mode == $past(reg_wdata))
        else $error("write beside software reset was lost");

    pin_ignored_a: assert property (
        !(reg_write && reg_hit) |=> $stable(state.mode.rom_select_mode))
        else $error("rom select bit moved without a write");

    read_idle_a: assert property (
        !(reg_read && reg_hit) |=> reg_rdata == 16'h0000)
        else $error("read data stood outside the read cycle");

    one_select_a: assert property (
        1'b1 |-> $onehot0(prog_select) && $onehot0(data_select))
        else $error("more than one target decoded for one access");

    page_zero_data_a: assert property (
        data_access.valid && data_access.addr <= 16'h007f |=>
            !data_select.ram && !data_select.external)
        else $error("data page 0 decoded as ram or external");

    store_plain_a: assert property (
        !state.mode.store_saturate |=>
            store_data == $past(store_value[15:0]))
        else $error("store word changed while saturation is off");

endmodule

// >>> test/pmsr_top_tb.sv
// Self-checking bench for the processor mode status block
`timescale 1ns/1ps
module pmsr_top_tb;
    import pmsr_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst, pin, soft_reset, reg_write, reg_read;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, ext_addr, vector_addr, store_data;
    pmsr_access_type prog_access, data_access;
    pmsr_select_type prog_select, data_select;
    logic [4:0] vector_index;
    logic clock_output_pin, overflow_mode, fractional_mode, seen;
    logic signed [15:0] mul_a, mul_b;
    logic [31:0] mul_product, r;
    logic [39:0] store_value;
    logic [15:0] mode, last_ext;
    logic [15:0] tbl [9] = '{16'h0000, 16'h007f, 16'h0080, 16'h9fff,
        16'ha000, 16'hc000, 16'hf000, 16'hfeff, 16'hffff};
    logic [31:0] seed = 32'd25836;
    logic [47:0] rq [$];
    logic [47:0] oq [$];
    logic rd_d1 = 1'b0;
    int ck, ck_d, error_cnt, compares;

    pmsr_top #(.CLK_OUT_HALF_CYCLES(1)) i_pmsr_top (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .rom_select_mode_pin(pin),
        .soft_reset(soft_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .prog_access(prog_access),
        .data_access(data_access), .prog_select(prog_select),
        .data_select(data_select), .ext_addr(ext_addr),
        .vector_index(vector_index), .vector_addr(vector_addr),
        .clock_output_pin(clock_output_pin), .overflow_mode(overflow_mode),
        .fractional_mode(fractional_mode), .mul_a(mul_a), .mul_b(mul_b),
        .mul_product(mul_product), .store_value(store_value),
        .store_data(store_data));

    always #5 clk_sys = ~clk_sys;

    // **********************************************************************
    // Expectation models and checking
    // **********************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [21:0] dec_exp(logic pv, logic [15:0] pa,
        logic dv, logic [15:0] da);
        logic pr, pm, pe, dr, dm, de;
        pr = pv && pa >= 16'hc000 && !mode[6];
        pm = pv && !pr && mode[5] && pa >= 16'h0080 && pa <= 16'h9fff;
        pe = pv && !pr && !pm;
        dm = dv && da >= 16'h0080 && da <= 16'h9fff;
        dr = dv && !dm && mode[3] && da >= 16'hf000 && da <= 16'hfeff;
        de = dv && !dm && !dr && da >= 16'h0080;
        if ((mode[4] && pv) || pe)
            last_ext = pa;
        else if (de)
            last_ext = da;
        return {pr, pm, pe, dr, dm, de, last_ext};
    endfunction

    function automatic logic [47:0] ari_exp(logic signed [15:0] a,
        logic signed [15:0] b, logic ov, logic fr, logic signed [39:0] sv);
        logic signed [32:0] p;
        logic [31:0] q;
        logic [15:0] s;
        p = a * b;
        if (fr)
            p = p <<< 1;
        q = p[31:0];
        if (mode[1] && ov && fr && p > 33'sh0_7fff_ffff)
            q = 32'h7fff_ffff;
        else if (mode[1] && ov && fr && p < -33'sd2147483648)
            q = 32'h8000_0000;
        s = sv[15:0];
        if (mode[0] && sv > 40'sh00_0000_7fff)
            s = 16'h7fff;
        else if (mode[0] && sv < -40'sd32768)
            s = 16'h8000;
        return {s, q};
    endfunction

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge clk_sys)
    begin
        ck_d <= ck;
        rd_d1 <= reg_read;
    end

    always @(negedge clk_sys)
    begin
        if (rd_d1 === 1'b1)
            check({32'h0, reg_rdata},
                rq.pop_front());
        if (ck_d == 2)
            check({26'h0, prog_select, data_select, ext_addr},
                oq.pop_front());
        if (ck_d == 5)
            check({store_data, mul_product}, oq.pop_front());
        if (ck_d == 7)
            check({32'h0, vector_addr}, oq.pop_front());
        if (ck_d == 8)
            check({47'h0, clock_output_pin}, oq.pop_front());
    end

    // **********************************************************************
    // Drivers
    // **********************************************************************
    task automatic quiet(input int k, input logic clr);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        ck <= k;
        if (clr)
        begin
            prog_access.valid <= 1'b0;
            data_access.valid <= 1'b0;
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge clk_sys);
        reg_write <= wr;
        reg_read <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        ck <= 0;
        prog_access.valid <= 1'b0;
        data_access.valid <= 1'b0;
        if (wr && a == 8'h1d)
            mode = d;
        if (!wr)
            rq.push_back({32'h0, (a == 8'h1d) ? mode : 16'h0});
    endtask

    task automatic idle(input int k, input logic [47:0] e);
        @(posedge clk_sys);
        quiet(k, 1'b1);
        if (k != 0)
            oq.push_back(e);
    endtask

    task automatic vec(input logic [4:0] idx);
        @(posedge clk_sys);
        quiet(7, 1'b1);
        vector_index <= idx;
        oq.push_back({32'h0, mode[15:7], idx, 2'b00});
    endtask

    task automatic dec(input logic pv, input logic [15:0] pa,
        input logic dv, input logic [15:0] da);
        @(posedge clk_sys);
        quiet(2, 1'b0);
        prog_access <= '{valid: pv, addr: pa};
        data_access <= '{valid: dv, addr: da};
        oq.push_back({26'h0, dec_exp(pv, pa, dv, da)});
    endtask

    task automatic ari(input logic [15:0] a, input logic [15:0] b,
        input logic ov, input logic fr, input logic [39:0] sv);
        @(posedge clk_sys);
        quiet(5, 1'b1);
        mul_a <= a;
        mul_b <= b;
        overflow_mode <= ov;
        fractional_mode <= fr;
        store_value <= sv;
        oq.push_back(ari_exp(a, b, ov, fr, sv));
    endtask

    task automatic conclude();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        {sys_rst, pin, soft_reset, reg_write, reg_read} = 5'h18;
        {reg_addr, reg_wdata, vector_index, overflow_mode} = '0;
        {fractional_mode, mul_a, mul_b, store_value, last_ext} = '0;
        prog_access = '0;
        data_access = '0;
        ck = 0;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        mode = 16'hffc0;
        bus(0, 8'h1d, 16'h0);
        pin <= 1'b0;
        vec(5'h1f);
        bus(0, 8'h1d, 16'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            bus(1, 8'h1d, 16'(rnd()));
            bus(0, 8'h1d, 16'h0);
            vec(5'(rnd()));
        end
        bus(1, 8'h1e, 16'(rnd()));
        bus(0, 8'h1e, 16'h0);
        bus(0, 8'h1d, 16'h0);
        bus(1, 8'h1d, 16'h127f);
        @(posedge clk_sys);
        quiet(0, 1'b1);
        soft_reset <= 1'b1;
        mode = {mode[15:6], 6'h00};
        @(posedge clk_sys);
        soft_reset <= 1'b0;
        bus(0, 8'h1d, 16'h0);
        bus(1, 8'h1d, 16'h5aa5);
        soft_reset <= 1'b1;
        bus(0, 8'h1d, 16'h0);
        soft_reset <= 1'b0;
        $display("test registers done");
        for (int m = 0; m < 16; m++)
        begin
            bus(1, 8'h1d, {9'h1ff, m[0], m[1], m[3], m[2], 3'h0});
            for (int i = 0; i < 9; i++)
                dec(i % 4 != 3, tbl[i], i != 4, tbl[(i + m) % 9]);
        end
        $display("test decode done");
        for (int i = 0; i < 16; i++)
        begin
            r = rnd();
            bus(1, 8'h1d, {14'h3fe0, (i == 0) ? 2'b11 : r[1:0]});
            if (i == 0)
                ari(16'h8000, 16'h8000, 1'b1, 1'b1, 40'h80_0000_0000);
            else
                ari(16'(rnd()), 16'(rnd()), r[2], r[3], 40'({rnd(), rnd()}));
        end
        $display("test arithmetic done");
        bus(1, 8'h1d, 16'hff84);
        idle(0, 48'h0);
        idle(0, 48'h0);
        repeat (6) idle(8, 48'h1);
        bus(1, 8'h1d, 16'hff80);
        repeat (3) idle(0, 48'h0);
        @(negedge clk_sys);
        seen = clock_output_pin;
        @(negedge clk_sys);
        check({47'h0, clock_output_pin}, {47'h0, ~seen});
        $display("test clock output done");
        bus(1, 8'h1d, 16'h0a7f);
        @(posedge clk_sys);
        quiet(0, 1'b1);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        mode = 16'hff80;
        bus(0, 8'h1d, 16'h0);
        vec(5'h00);
        repeat (4) idle(0, 48'h0);
        $display("test second reset done");
        conclude();
    end
endmodule
